/* File: verilog/twb_order_buffer.sv */
// twb_order_buffer: ordering-preserving posted write buffer between masters and a downstream slave port
module twb_order_buffer #(
    parameter int DRAIN_CYC = twb_pkg::DRAIN_CYC,
    parameter int FWD_CYC   = twb_pkg::FWD_CYC
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // upstream request
    input  wire logic              up_req_valid,
    output logic                   up_req_ready,
    input  wire twb_pkg::twb_req_t up_req,
    // upstream response
    output logic                   up_rsp_valid,
    input  wire logic              up_rsp_ready,
    output twb_pkg::twb_rsp_t      up_rsp,
    // downstream request
    output logic                   dn_req_valid,
    input  wire logic              dn_req_ready,
    output twb_pkg::twb_req_t      dn_req,
    // downstream response
    input  wire logic              dn_rsp_valid,
    output logic                   dn_rsp_ready,
    input  wire twb_pkg::twb_rsp_t dn_rsp
);

    // ==========================================================
    // state
    twb_pkg::twb_state_t state_q;
    twb_pkg::twb_state_t state_d;
    twb_pkg::twb_req_t   dn_req_q;
    twb_pkg::twb_rsp_t   up_rsp_q;

    logic              held_valid;
    twb_pkg::twb_req_t held;
    logic              drain_due;
    logic              fwd_live;

    // ==========================================================
    // comparison of the incoming request against the held write
    wire logic idle        = (state_q == twb_pkg::S_IDLE);
    wire logic up_dev      = twb_pkg::is_device(up_req.cache);
    wire logic held_dev    = twb_pkg::is_device(held.cache);
    wire logic up_post     = twb_pkg::is_postable(up_req.cache);
    wire logic up_fwdable  = twb_pkg::is_forwardable(up_req.cache);
    wire logic same_word   = held_valid
                           && (held.addr[twb_pkg::ADDR_W-1:twb_pkg::WORD_LSB]
                               == up_req.addr[twb_pkg::ADDR_W-1:twb_pkg::WORD_LSB]);
    wire logic overlap     = held_valid
                           && (held.addr[twb_pkg::ADDR_W-1:twb_pkg::ATOM_LSB]
                               == up_req.addr[twb_pkg::ADDR_W-1:twb_pkg::ATOM_LSB]);
    wire logic same_slave  = held_valid
                           && (held.addr[twb_pkg::ADDR_W-1:twb_pkg::SLAVE_LSB]
                               == up_req.addr[twb_pkg::ADDR_W-1:twb_pkg::SLAVE_LSB]);
    wire logic same_id     = held_valid && (held.id == up_req.id);
    wire logic full_word   = &held.strb;

    // device traffic of one ID to one slave may not pass the held write
    wire logic dev_order   = same_id && same_slave && (up_dev || held_dev);
    wire logic conflict    = overlap || dev_order;

    // device writes are never merged; merging keeps to one ID so early answers stay in order
    wire logic can_alloc   = up_req.write && up_post && !held_valid;
    wire logic can_merge   = up_req.write && up_post && !up_dev && !held_dev
                           && same_word && same_id;
    // device reads always go downstream; forwarding stops once the held data ages out
    wire logic can_fwd     = !up_req.write && up_fwdable && !held_dev
                           && same_word && full_word && fwd_live;

    wire logic must_flush  = up_req_valid && !can_merge && !can_fwd
                           && (conflict || (up_req.write && up_post));
    // an aged write drains ahead of any new request, so merge traffic cannot starve it
    wire logic go_flush    = idle && held_valid && (drain_due || must_flush);
    wire logic take        = idle && up_req_valid && !go_flush;
    wire logic take_post   = take && (can_alloc || can_merge);
    wire logic take_fwd    = take && can_fwd;
    wire logic take_pass   = take && !(can_alloc || can_merge) && !can_fwd;
    wire logic flush_done  = (state_q == twb_pkg::S_FLUSH_WAIT) && dn_rsp_valid;
    wire logic pass_done   = (state_q == twb_pkg::S_PASS_WAIT) && dn_rsp_valid;

    // ==========================================================
    // held write
    twb_hold_entry #(
        .DRAIN_CYC (DRAIN_CYC),
        .FWD_CYC   (FWD_CYC)
    ) u_entry (
        .clock      (clock),
        .resetn     (resetn),
        .alloc      (take_post && can_alloc),
        .merge      (take_post && can_merge),
        .clear      (flush_done),
        .in_req     (up_req),
        .held_valid (held_valid),
        .held       (held),
        .drain_due  (drain_due),
        .fwd_live   (fwd_live)
    );

    // ==========================================================
    // sequencing: one upstream transaction at a time, one downstream at a time
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            twb_pkg::S_IDLE: begin
                if (go_flush) begin
                    state_d = twb_pkg::S_FLUSH;
                end else if (take_pass) begin
                    state_d = twb_pkg::S_PASS;
                end else if (take_post || take_fwd) begin
                    state_d = twb_pkg::S_RESP;
                end
            end
            twb_pkg::S_PASS: begin
                if (dn_req_ready) begin
                    state_d = twb_pkg::S_PASS_WAIT;
                end
            end
            twb_pkg::S_PASS_WAIT: begin
                if (dn_rsp_valid) begin
                    state_d = twb_pkg::S_RESP;
                end
            end
            twb_pkg::S_FLUSH: begin
                if (dn_req_ready) begin
                    state_d = twb_pkg::S_FLUSH_WAIT;
                end
            end
            // the blocked request is re-examined only after the drained write is acknowledged
            twb_pkg::S_FLUSH_WAIT: begin
                if (dn_rsp_valid) begin
                    state_d = twb_pkg::S_IDLE;
                end
            end
            twb_pkg::S_RESP: begin
                if (up_rsp_ready) begin
                    state_d = twb_pkg::S_IDLE;
                end
            end
            default: state_d = twb_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= twb_pkg::S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // downstream request register; ids travel unchanged
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dn_req_q <= '0;
        end else if (go_flush) begin
            dn_req_q <= held;
        end else if (take_pass) begin
            dn_req_q <= up_req;
        end
    end

    // ==========================================================
    // upstream response register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            up_rsp_q <= '0;
        end else if (take_post) begin
            up_rsp_q <= '{write: 1'b1, id: up_req.id, data: '0, resp: twb_pkg::RESP_OKAY};
        end else if (take_fwd) begin
            up_rsp_q <= '{write: 1'b0, id: up_req.id, data: held.data, resp: twb_pkg::RESP_OKAY};
        end else if (pass_done) begin
            up_rsp_q <= dn_rsp;
        end
    end

    // ==========================================================
    // handshakes
    assign up_req_ready = take;
    assign up_rsp_valid = (state_q == twb_pkg::S_RESP);
    assign up_rsp       = up_rsp_q;
    assign dn_req_valid = (state_q == twb_pkg::S_PASS) || (state_q == twb_pkg::S_FLUSH);
    assign dn_req       = dn_req_q;
    assign dn_rsp_ready = (state_q == twb_pkg::S_PASS_WAIT) || (state_q == twb_pkg::S_FLUSH_WAIT);

endmodule // twb_order_buffer

/* File: common/twb_pkg.sv */
// twb_pkg: shared widths, carriers, cache attribute decode and timing of the ordering write buffer
package twb_pkg;

    // ==========================================================
    // widths and address granules
    localparam int ADDR_W    = 32;
    localparam int ID_W      = 4;
    localparam int DATA_W    = 32;
    localparam int STRB_W    = DATA_W / 8;
    localparam int CACHE_W   = 4;
    localparam int RESP_W    = 2;
    localparam int WORD_LSB  = 2;   // byte address bits inside one data word
    localparam int ATOM_LSB  = 2;   // single-copy atomic granule, 4 bytes
    localparam int SLAVE_LSB = 12;  // smallest slave footprint, 4 KB
    localparam int AGE_W     = 16;

    // ==========================================================
    // cache attribute bit positions
    localparam int CACHE_BUF_BIT = 0;
    localparam int CACHE_MOD_BIT = 1;
    localparam int CACHE_RA_BIT  = 2;
    localparam int CACHE_WA_BIT  = 3;

    localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;

    // ==========================================================
    // timing: times in ns, counts derived from the clock period (rounded down, at least one)
    localparam int CLK_PERIOD_NS = 10;
    localparam int DRAIN_TIME_NS = 2000;
    localparam int FWD_TIME_NS   = 500;
    localparam int DRAIN_CYC = (DRAIN_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : DRAIN_TIME_NS / CLK_PERIOD_NS;
    localparam int FWD_CYC   = (FWD_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : FWD_TIME_NS / CLK_PERIOD_NS;

    // ==========================================================
    // carriers
    typedef logic [AGE_W-1:0] twb_age_t;

    typedef struct packed {
        logic                write;
        logic [ID_W-1:0]     id;
        logic [ADDR_W-1:0]   addr;
        logic [CACHE_W-1:0]  cache;
        logic [DATA_W-1:0]   data;
        logic [STRB_W-1:0]   strb;
    } twb_req_t;

    typedef struct packed {
        logic                write;
        logic [ID_W-1:0]     id;
        logic [DATA_W-1:0]   data;
        logic [RESP_W-1:0]   resp;
    } twb_rsp_t;

    typedef enum logic [2:0] {
        S_IDLE       = 3'h0,
        S_PASS       = 3'h1,
        S_PASS_WAIT  = 3'h2,
        S_FLUSH      = 3'h3,
        S_FLUSH_WAIT = 3'h4,
        S_RESP       = 3'h5
    } twb_state_t;

    // ==========================================================
    // attribute decode
    function automatic logic is_device(input logic [CACHE_W-1:0] c);
        return ~c[CACHE_MOD_BIT];
    endfunction

    function automatic logic is_cacheable(input logic [CACHE_W-1:0] c);
        return c[CACHE_RA_BIT] | c[CACHE_WA_BIT];
    endfunction

    // device bufferable, normal non-cacheable bufferable, write-through / write-back
    function automatic logic is_postable(input logic [CACHE_W-1:0] c);
        return c[CACHE_BUF_BIT] | is_cacheable(c);
    endfunction

    // normal non-cacheable bufferable or cacheable: reads may be served from held write data
    function automatic logic is_forwardable(input logic [CACHE_W-1:0] c);
        return ~is_device(c) & is_postable(c);
    endfunction

endpackage

/* File: verilog/twb_hold_entry.sv */
// twb_hold_entry: one held posted write with byte merging and a non-restartable age timer
module twb_hold_entry #(
    parameter int DRAIN_CYC = twb_pkg::DRAIN_CYC,
    parameter int FWD_CYC   = twb_pkg::FWD_CYC
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // control
    input  wire logic             alloc,
    input  wire logic             merge,
    input  wire logic             clear,
    input  wire twb_pkg::twb_req_t in_req,
    // state
    output logic                  held_valid,
    output twb_pkg::twb_req_t     held,
    output logic                  drain_due,
    output logic                  fwd_live
);

    // ==========================================================
    // storage
    localparam twb_pkg::twb_age_t DRAIN_LIM = twb_pkg::twb_age_t'(DRAIN_CYC);
    localparam twb_pkg::twb_age_t FWD_LIM   = twb_pkg::twb_age_t'(FWD_CYC);
    localparam twb_pkg::twb_age_t AGE_MAX   = '1;
    localparam twb_pkg::twb_age_t AGE_ONE   = twb_pkg::twb_age_t'(1);

    logic                  valid_q;
    twb_pkg::twb_req_t     held_q;
    twb_pkg::twb_age_t     age_q;
    logic [twb_pkg::DATA_W-1:0] merge_data;

    // ==========================================================
    // byte lane merge
    for (genvar b = 0; b < twb_pkg::STRB_W; b++) begin : g_lane
        assign merge_data[b*8 +: 8] = in_req.strb[b] ? in_req.data[b*8 +: 8] : held_q.data[b*8 +: 8];
    end

    // age only starts at allocation; merges and forwarding hits never reset it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            valid_q <= 1'b0;
            held_q  <= '0;
            age_q   <= '0;
        end else if (clear) begin
            valid_q <= 1'b0;
            age_q   <= '0;
        end else if (alloc) begin
            valid_q <= 1'b1;
            held_q  <= in_req;
            age_q   <= '0;
        end else begin
            if (merge) begin
                held_q.data <= merge_data;
                held_q.strb <= held_q.strb | in_req.strb;
            end
            if (valid_q && age_q != AGE_MAX) begin
                age_q <= age_q + AGE_ONE;
            end
        end
    end

    assign held_valid = valid_q;
    assign held       = held_q;
    assign drain_due  = valid_q && (age_q >= DRAIN_LIM - AGE_ONE);
    assign fwd_live   = valid_q && (age_q < FWD_LIM);

endmodule // twb_hold_entry

/* File: verification/twb_order_buffer_properties.sv */
// twb_order_buffer_properties: port-level checker for the ordering write buffer
module twb_order_buffer_checker #(
    parameter int DRAIN_CYC = twb_pkg::DRAIN_CYC,
    parameter int FWD_CYC   = twb_pkg::FWD_CYC
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              resetn,
    // upstream
    input wire logic              up_req_valid,
    input wire logic              up_req_ready,
    input wire twb_pkg::twb_req_t up_req,
    input wire logic              up_rsp_valid,
    input wire logic              up_rsp_ready,
    input wire twb_pkg::twb_rsp_t up_rsp,
    // downstream
    input wire logic              dn_req_valid,
    input wire logic              dn_req_ready,
    input wire twb_pkg::twb_req_t dn_req,
    input wire logic              dn_rsp_valid,
    input wire logic              dn_rsp_ready,
    input wire twb_pkg::twb_rsp_t dn_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // helpers
    localparam int DRAIN_LIM = DRAIN_CYC + 40;
    logic               take;
    logic               posted;
    twb_pkg::twb_age_t  since_q;
    assign take   = up_req_valid && up_req_ready;
    assign posted = up_req.cache[0] | (|up_req.cache[3:2]);
    // cycles since the last write was taken; saturates so an empty buffer reads as expired
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) since_q <= '1;
        else if (take && up_req.write) since_q <= '0;
        else if (since_q != '1) since_q <= since_q + 1'b1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // assertions
    property p_dn_hold;
        dn_req_valid && !dn_req_ready |=> dn_req_valid && $stable(dn_req);
    endproperty
    a_dn_hold: assert property (p_dn_hold) else $error("downstream request changed before accept");
    property p_up_hold;
        up_rsp_valid && !up_rsp_ready |=> up_rsp_valid && $stable(up_rsp);
    endproperty
    a_up_hold: assert property (p_up_hold) else $error("upstream response changed before accept");
    property p_dev_read;
        take && !up_req.write && !up_req.cache[1] |=> !up_rsp_valid ##0 dn_req_valid && !dn_req.write
            && dn_req.addr == $past(up_req.addr);
    endproperty
    a_dev_read: assert property (p_dev_read) else $error("device read not sent downstream");
    property p_posted;
        take && up_req.write && posted |=> up_rsp_valid && up_rsp.write && up_rsp.id == $past(up_req.id);
    endproperty
    a_posted: assert property (p_posted) else $error("posted write not answered early");
    property p_nonbuf;
        take && up_req.write && !posted |=> !up_rsp_valid ##0 dn_req_valid && dn_req.write
            && dn_req.data == $past(up_req.data);
    endproperty
    a_nonbuf: assert property (p_nonbuf) else $error("non-bufferable write answered early");
    property p_one_flight;
        up_rsp_valid || dn_req_valid || dn_rsp_ready |-> !up_req_ready;
    endproperty
    a_one_flight: assert property (p_one_flight) else $error("request taken while busy");
    property p_drain;
        take && up_req.write && posted |-> ##[1:DRAIN_LIM] (dn_req_valid && dn_req.write);
    endproperty
    a_drain: assert property (p_drain) else $error("held write never drained");
    property p_fwd_expiry;
        take && !up_req.write && since_q >= FWD_CYC |=> !up_rsp_valid;
    endproperty
    a_fwd_expiry: assert property (p_fwd_expiry) else $error("read served from expired data");
    property p_rsp_cause;
        $rose(dn_rsp_ready) |-> $past(dn_req_valid && dn_req_ready);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause) else $error("waiting for response without request");
endmodule // twb_order_buffer_checker

bind twb_order_buffer twb_order_buffer_checker #(.DRAIN_CYC(DRAIN_CYC), .FWD_CYC(FWD_CYC)) i_twb_order_buffer_checker (
    .clock(clock), .resetn(resetn), .up_req_valid(up_req_valid), .up_req_ready(up_req_ready), .up_req(up_req),
    .up_rsp_valid(up_rsp_valid), .up_rsp_ready(up_rsp_ready), .up_rsp(up_rsp), .dn_req_valid(dn_req_valid),
    .dn_req_ready(dn_req_ready), .dn_req(dn_req), .dn_rsp_valid(dn_rsp_valid), .dn_rsp_ready(dn_rsp_ready),
    .dn_rsp(dn_rsp));

/* File: verification/twb_slave_model.sv */
// twb_slave_model: downstream memory slave with optional stalls
module twb_slave_model (
    // clock and reset
    input wire logic              clock,
    input wire logic              resetn,
    // pacing
    input wire logic              slow,
    // request
    input wire logic              dn_req_valid,
    output logic                  dn_req_ready,
    input wire twb_pkg::twb_req_t dn_req,
    // response
    output logic                  dn_rsp_valid,
    input wire logic              dn_rsp_ready,
    output twb_pkg::twb_rsp_t     dn_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0]       mem [64];
    logic [31:0]       seen_q;
    twb_pkg::twb_req_t last_q;
    twb_pkg::twb_rsp_t rsp_q;
    logic              pend_q;
    logic [1:0]        wait_q;
    logic [1:0]        lat_q;
    assign dn_req_ready = dn_req_valid && !pend_q && (wait_q == 2'h0);
    assign dn_rsp_valid = pend_q && (lat_q == 2'h0);
    // released lines show the inverse so a stale value never passes
    assign dn_rsp       = dn_rsp_valid ? rsp_q : ~rsp_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            wait_q <= 2'h0;
            lat_q  <= 2'h0;
            seen_q <= 32'h0;
            last_q <= '0;
            rsp_q  <= '0;
        end else begin
            if (dn_req_ready) begin
                pend_q <= 1'b1;
                lat_q  <= slow ? 2'h3 : 2'h0;
                wait_q <= slow ? 2'h2 : 2'h0;
                seen_q <= seen_q + 32'h1;
                last_q <= dn_req;
                // read data always from the array: this is the final destination
                rsp_q  <= {dn_req.write, dn_req.id, dn_req.write ? 32'h0 : mem[dn_req.addr[7:2]], twb_pkg::RESP_OKAY};
                for (int b = 0; b < 4; b++)
                    if (dn_req.write && dn_req.strb[b]) mem[dn_req.addr[7:2]][8*b +: 8] <= dn_req.data[8*b +: 8];
            end else if (dn_req_valid && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
            if (pend_q && lat_q != 2'h0) lat_q <= lat_q - 2'h1;
            if (dn_rsp_valid && dn_rsp_ready) pend_q <= 1'b0;
        end
    end
endmodule // twb_slave_model

/* File: verification/tb_twb_order_buffer.sv */
// tb_twb_order_buffer: scenario testbench for the ordering write buffer
module tb_twb_order_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DRAIN = 30;
    localparam int FWD   = 3;
    logic              clock = 1'b0;
    logic              resetn, slow, up_req_valid, up_req_ready, up_rsp_valid, up_rsp_ready;
    logic              dn_req_valid, dn_req_ready, dn_rsp_valid, dn_rsp_ready;
    twb_pkg::twb_req_t up_req, dn_req;
    twb_pkg::twb_rsp_t up_rsp, dn_rsp, r;
    int                fail_count = 0, checked = 0, cycles = 0, lat;
    always #5 clock = ~clock;
    twb_order_buffer #(.DRAIN_CYC(DRAIN), .FWD_CYC(FWD)) i_twb_order_buffer (.clock(clock), .resetn(resetn),
        .up_req_valid(up_req_valid), .up_req_ready(up_req_ready), .up_req(up_req), .up_rsp_valid(up_rsp_valid),
        .up_rsp_ready(up_rsp_ready), .up_rsp(up_rsp), .dn_req_valid(dn_req_valid), .dn_req_ready(dn_req_ready),
        .dn_req(dn_req), .dn_rsp_valid(dn_rsp_valid), .dn_rsp_ready(dn_rsp_ready), .dn_rsp(dn_rsp));
    twb_slave_model i_twb_slave_model (.clock(clock), .resetn(resetn), .slow(slow), .dn_req_valid(dn_req_valid),
        .dn_req_ready(dn_req_ready), .dn_req(dn_req), .dn_rsp_valid(dn_rsp_valid), .dn_rsp_ready(dn_rsp_ready),
        .dn_rsp(dn_rsp));
    // ==========================================================
    // shared tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single-beat transaction; masters hold the request until taken
    task automatic xact(input logic wr, input logic [3:0] id, input logic [31:0] addr, input logic [3:0] cache,
                        input logic [31:0] data, input logic [3:0] strb);
        int n;
        n = 0;
        up_req = {wr, id, addr, cache, data, strb};
        up_req_valid = 1'b1;
        do @(posedge clock); while (up_req_ready !== 1'b1 && n++ < 200);
        if (up_req_ready !== 1'b1) fail_count++;
        #1 up_req_valid = 1'b0;
        lat = 0;
        do begin
            @(posedge clock);
            lat++;
        end while (up_rsp_valid !== 1'b1 && lat < 200);
        if (up_rsp_valid !== 1'b1) fail_count++;
        r = up_rsp;
        #1;
    endtask
    // ==========================================================
    // scenarios
    task automatic s_merge_drain();
        logic [31:0] s0;
        s0 = i_twb_slave_model.seen_q;
        xact(1'b1, 4'h1, 32'h100, 4'h3, 32'h1111_1111, 4'hf);
        check(lat, 1);
        check({r.write, r.resp}, {1'b1, twb_pkg::RESP_OKAY});
        check(i_twb_slave_model.seen_q, s0);
        // each merge costs two cycles, so this many outlast the drain timer; the held word must still leave
        for (int k = 0; k < DRAIN / 2 + 1; k++) xact(1'b1, 4'h1, 32'h100, 4'h3, 32'haaaa_aaaa, 4'h1 << (k % 4));
        check(i_twb_slave_model.seen_q != s0, 1);
        repeat (DRAIN + 20) @(posedge clock);
        #1;
        check(i_twb_slave_model.mem[0], 32'haaaa_aaaa);
    endtask
    task automatic s_forward();
        xact(1'b1, 4'h2, 32'h200, 4'h3, 32'h2222_2222, 4'hf);
        for (int k = 0; k < FWD + 3; k++) begin
            xact(1'b0, 4'h5, 32'h200, 4'h3, 32'h0, 4'h0);
            check(r.data, 32'h2222_2222);
        end
        check(i_twb_slave_model.last_q.write, 0);
        check(i_twb_slave_model.last_q.addr, 32'h200);
        xact(1'b1, 4'h2, 32'h240, 4'h6, 32'h6666_6666, 4'hf);
        xact(1'b0, 4'h2, 32'h240, 4'ha, 32'h0, 4'h0);
        check(r.data, 32'h6666_6666);
        // device read of a normal region: same id and slave as the held write, so that write leaves first
        xact(1'b0, 4'h2, 32'h200, 4'h0, 32'h0, 4'h0);
        check(r.data, 32'h2222_2222);
        check(i_twb_slave_model.mem[16], 32'h6666_6666);
    endtask
    task automatic s_device_read();
        logic [31:0] s0;
        slow = 1'b1;
        s0 = i_twb_slave_model.seen_q;
        xact(1'b1, 4'h3, 32'h300, 4'h1, 32'h3333_3333, 4'hf);
        check(lat, 1);
        xact(1'b0, 4'h3, 32'h300, 4'h0, 32'h0, 4'h0);
        check(r.data, 32'h3333_3333);
        check(i_twb_slave_model.seen_q - s0, 2);
        check(i_twb_slave_model.last_q.write, 0);
    endtask
    task automatic s_barrier();
        xact(1'b1, 4'h4, 32'h1000, 4'h1, 32'h4444_4444, 4'hf);
        xact(1'b1, 4'h4, 32'h1010, 4'h0, 32'h5555_5555, 4'hf);
        check(i_twb_slave_model.mem[0], 32'h4444_4444);
        check(i_twb_slave_model.last_q.addr, 32'h1010);
        check(r.id, 4);
    endtask
    task automatic s_resp_order();
        for (int k = 0; k < 3; k++) begin
            if (k == 1) up_rsp_ready = 1'b0;
            xact(1'b0, 4'h6 + 4'(k % 2), 32'h1000 + 32'(k % 2) * 32'h10, 4'h0, 32'h0, 4'h0);
            check(r.id, 6 + k % 2);
            check(r.data, (k % 2) ? 32'h5555_5555 : 32'h4444_4444);
            if (k == 1) begin
                // a response the master is not ready for must stand unchanged
                @(posedge clock);
                #1;
                check(up_rsp_valid, 1);
                check(up_rsp.data, 32'h5555_5555);
                up_rsp_ready = 1'b1;
                @(posedge clock);
                #1;
            end
        end
    endtask
    // ==========================================================
    // sequence and timeout
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        resetn = 1'b0;
        slow = 1'b0;
        up_req_valid = 1'b0;
        up_req = '0;
        up_rsp_ready = 1'b1;
        repeat (6) @(posedge clock);
        #1 resetn = 1'b1;
        s_merge_drain();
        s_forward();
        s_device_read();
        s_barrier();
        s_resp_order();
        wrap_up();
    end
endmodule // tb_twb_order_buffer
